// ==== include/tsi2c_pkg.sv ====
// Constants and types shared by the two-wire slave port
package tsi2c_pkg;

  // Address bytes and general-call commands
  localparam logic [3:0] ADDR_PREFIX = 4'h9;
  localparam logic [6:0] GCALL_ADDR  = 7'h00;
  localparam logic [7:0] ARA_BYTE    = 8'h19;
  localparam logic [7:0] GC_RELATCH  = 8'h04;
  localparam logic [7:0] GC_RESET    = 8'h06;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;

  // Pointer values
  localparam logic [1:0] PTR_TEMP  = 2'h0;
  localparam logic [1:0] PTR_CFG   = 2'h1;
  localparam logic [1:0] PTR_TLOW  = 2'h2;
  localparam logic [1:0] PTR_THIGH = 2'h3;
  localparam logic [1:0] PTR_RST   = 2'h0;

  // Register reset values and fields
  localparam logic [15:0] CFG_RST     = 16'h00ff;
  localparam logic [15:0] TLOW_RST    = 16'h0000;
  localparam logic [15:0] THIGH_RST   = 16'h0000;
  localparam logic [7:0]  CFG_RSVD    = 8'hff;
  localparam int          CFG_OS_BIT  = 15;
  localparam int          CFG_TM_BIT  = 9;

  // Bus timeout
  localparam int TIMEOUT_US  = 54000;
  localparam int MCLK_KHZ    = 25000;
  localparam int TIMEOUT_CYC = TIMEOUT_US * MCLK_KHZ / 1000;
  localparam int TO_W        = 21;

  typedef enum logic [2:0] {
    RQ_READ, RQ_WRHI, RQ_WRLO, RQ_GCRST, RQ_ARAWIN
  } tsi2c_req_e;

  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_RXBYTE, LK_ACK, LK_TXBYTE, LK_TXACK, LK_TXNEXT,
    LK_WAIT
  } tsi2c_link_e;

  typedef enum logic [1:0] {MD_WRITE, MD_READ, MD_GCALL, MD_ARA} tsi2c_mode_e;

endpackage

// ==== rtl/tsi2c_regfile.sv ====
// Pointer-addressed register store with registered read data
`timescale 1ns/100ps
module tsi2c_regfile (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Access
  input  wire logic        clearAll,
  input  wire logic        wrEn,
  input  wire logic        wrHi,
  input  wire logic [1:0]  ptr,
  input  wire logic [7:0]  wrData,
  output logic      [15:0] rdData,
  // Device side
  input  wire logic [11:0] tempWord,
  output logic      [15:0] cfgWord,
  output logic      [15:0] tLowWord,
  output logic      [15:0] tHighWord,
  output logic             oneShotStart
);
  import tsi2c_pkg::*;

  logic [7:0]  cfgHi_q;
  logic [11:0] tLow_q;
  logic [11:0] tHigh_q;

  // Single-byte writes keep the other half untouched
  always_ff @(posedge mclk) begin
    if (!rstn || clearAll) begin
      cfgHi_q <= CFG_RST[15:8];
      tLow_q  <= TLOW_RST[15:4];
      tHigh_q <= THIGH_RST[15:4];
    end else if (wrEn) begin
      unique case (ptr)
        PTR_TEMP: begin
        end
        PTR_CFG: if (wrHi) begin
          cfgHi_q <= {1'b0, wrData[6:0]};
        end
        PTR_TLOW: if (wrHi) begin
          tLow_q[11:4] <= wrData;
        end else begin
          tLow_q[3:0] <= wrData[7:4];
        end
        PTR_THIGH: if (wrHi) begin
          tHigh_q[11:4] <= wrData;
        end else begin
          tHigh_q[3:0] <= wrData[7:4];
        end
      endcase
    end
  end

  // One-shot request is a pulse; its bit reads back as zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      oneShotStart <= 1'b0;
    end else begin
      oneShotStart <= wrEn & wrHi & (ptr == PTR_CFG) &
                      wrData[CFG_OS_BIT-8];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdData <= 16'h0000;
    end else begin
      unique case (ptr)
        PTR_TEMP:  rdData <= {tempWord, 4'h0};
        PTR_CFG:   rdData <= cfgWord;
        PTR_TLOW:  rdData <= tLowWord;
        PTR_THIGH: rdData <= tHighWord;
      endcase
    end
  end

  assign cfgWord   = {cfgHi_q, CFG_RSVD};
  assign tLowWord  = {tLow_q, 4'h0};
  assign tHighWord = {tHigh_q, 4'h0};

endmodule

// ==== rtl/tsi2c_slave_port.sv ====
// Two-wire / SMBus slave port of the temperature sensor
`timescale 1ns/100ps
module tsi2c_slave_port #(
  parameter int TimeoutCyc = tsi2c_pkg::TIMEOUT_CYC
) (
  // Clocks and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        linkClk,
  // Two-wire pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Address straps
  input  wire logic        addrStrap0,
  input  wire logic        addrStrap1,
  input  wire logic        addrStrap2,
  // Sensor core
  input  wire logic [11:0] tempWord,
  input  wire logic        alertActive,
  input  wire logic        alertHigh,
  output logic             alertClear,
  output logic             gcReset,
  output logic             oneShotStart,
  output logic             alarmLatchingSelect,
  output logic      [15:0] cfgWord,
  output logic      [15:0] tLowWord,
  output logic      [15:0] tHighWord,
  output logic             hsMode
);
  import tsi2c_pkg::*;

  function automatic logic ownHit(input logic [7:0] b,
                                  input logic [2:0] s);
    return b[7:1] == {ADDR_PREFIX, s};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic        linkRstn;
  logic        sclS;
  logic        sdaS;
  logic [2:0]  strapS;
  logic        aActS;
  logic        aHiS;
  logic        tmS;
  logic        toTglS;
  logic        ackTglS;

  tsi2c_link_e state_q;
  tsi2c_mode_e mode_q;
  logic [2:0]  bitCnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  txByte_q;
  logic        byteDone_q;
  logic [1:0]  byteIdx_q;
  logic [1:0]  ptr_q;
  logic [2:0]  strap_q;
  logic        hsMode_q;
  logic        sdaOe_q;
  logic        inFrame_q;
  logic        sclP_q;
  logic        sdaP_q;
  logic        toTglP_q;
  logic        ackTglP_q;
  logic        reqTgl_q;
  tsi2c_req_e  reqKind_q;
  logic [1:0]  reqPtr_q;
  logic [7:0]  reqData_q;
  logic [15:0] rdWord_q;

  logic        sclRise;
  logic        sclFall;
  logic        startCond;
  logic        stopCond;
  logic        timeoutEv;
  logic        ackEv;
  logic        byteEnd;
  logic        prefetch;
  logic        isGc;
  logic        isAra;
  logic        isHs;
  logic        relatch;
  logic [7:0]  araByte;
  logic [7:0]  txSrc;
  logic        issue;
  tsi2c_req_e  issueKind;

  logic        reqTglS;
  logic        sclM;
  logic        sdaM;
  logic        frameM;
  logic        reqTglP_q;
  logic        reqEv;
  logic        rdDone_q;
  logic        ackTgl_q;
  logic        toTgl_q;
  logic [15:0] rspWord_q;
  logic [15:0] rdData;
  logic [TO_W-1:0] toCnt_q;
  logic        alertClr_q;
  logic        gcRst_q;

  ////////////////////////////////////////////////////////////////////////
  // Crossings into the link domain

  tsi2c_sync #(.W(1), .RST_VAL(1'b0)) uRstSync (
    .clk  (linkClk),
    .rstn (1'b1),
    .din  (rstn),
    .dout (linkRstn)
  );

  // Bus idles high, so the line samples reset high
  tsi2c_sync #(.W(10), .RST_VAL(10'h300)) uLinkSync (
    .clk  (linkClk),
    .rstn (linkRstn),
    .din  ({sclIn, sdaIn, addrStrap2, addrStrap1, addrStrap0,
            alertActive, alertHigh, alarmLatchingSelect, toTgl_q,
            ackTgl_q}),
    .dout ({sclS, sdaS, strapS, aActS, aHiS, tmS, toTglS, ackTglS})
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus conditions

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      sclP_q    <= 1'b1;
      sdaP_q    <= 1'b1;
      toTglP_q  <= 1'b0;
      ackTglP_q <= 1'b0;
    end else begin
      sclP_q    <= sclS;
      sdaP_q    <= sdaS;
      toTglP_q  <= toTglS;
      ackTglP_q <= ackTglS;
    end
  end

  assign sclRise   = sclS & ~sclP_q;
  assign sclFall   = ~sclS & sclP_q;
  assign startCond = sclS & sclP_q & sdaP_q & ~sdaS;
  assign stopCond  = sclS & sclP_q & ~sdaP_q & sdaS;
  assign timeoutEv = toTglS ^ toTglP_q;
  assign ackEv     = ackTglS ^ ackTglP_q;
  assign byteEnd   = sclFall & byteDone_q;

  assign isGc    = (shift_q[7:1] == GCALL_ADDR) & ~shift_q[0];
  assign isAra   = (shift_q == ARA_BYTE) & aActS & tmS;
  assign isHs    = shift_q[7:3] == HS_CODE_TOP;
  assign araByte = {ADDR_PREFIX, strap_q, aHiS};
  // ARA byte in ARA mode, else hi half when index is 1, lo half otherwise
  assign txSrc   = (mode_q == MD_ARA) ? araByte :
                   (byteIdx_q == 2'd1) ? rdWord_q[15:8] : rdWord_q[7:0];

  // Read fetched at the direction bit so data is back before the ack ends
  assign prefetch = (state_q == LK_ADDR) & sclRise & (bitCnt_q == 3'd7) &
                    sdaS & ownHit({shift_q[6:0], sdaS}, strap_q);
  assign relatch  = (state_q == LK_RXBYTE) & byteEnd &
                    (mode_q == MD_GCALL) & (byteIdx_q == 2'd0) &
                    (shift_q == GC_RELATCH);

  always_comb begin
    issue     = 1'b0;
    issueKind = RQ_READ;
    if (prefetch) begin
      issue = 1'b1;
    end else if ((state_q == LK_RXBYTE) & byteEnd &
                 (mode_q == MD_WRITE) & (byteIdx_q != 2'd0)) begin
      issue     = 1'b1;
      issueKind = (byteIdx_q == 2'd1) ? RQ_WRHI : RQ_WRLO;
    end else if ((state_q == LK_RXBYTE) & byteEnd &
                 (mode_q == MD_GCALL) & (byteIdx_q == 2'd0) &
                 (shift_q == GC_RESET)) begin
      issue     = 1'b1;
      issueKind = RQ_GCRST;
    end else if ((state_q == LK_TXACK) & sclRise &
                 (mode_q == MD_ARA)) begin
      issue     = 1'b1;
      issueKind = RQ_ARAWIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strap latch and speed mode

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      strap_q <= 3'h0;
    end else if (startCond || relatch) begin
      strap_q <= strapS;
    end
  end

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      hsMode_q <= 1'b0;
    end else if (stopCond || timeoutEv) begin
      hsMode_q <= 1'b0;
    end else if ((state_q == LK_ADDR) && byteEnd && isHs) begin
      hsMode_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte engine

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      state_q    <= LK_IDLE;
      mode_q     <= MD_WRITE;
      bitCnt_q   <= 3'd0;
      shift_q    <= 8'h00;
      txByte_q   <= 8'h00;
      byteDone_q <= 1'b0;
      byteIdx_q  <= 2'd0;
      ptr_q      <= PTR_RST;
      sdaOe_q    <= 1'b0;
      inFrame_q  <= 1'b0;
    end else if (timeoutEv) begin
      state_q   <= LK_IDLE;
      sdaOe_q   <= 1'b0;
      inFrame_q <= 1'b0;
    end else if (startCond) begin
      state_q    <= LK_ADDR;
      bitCnt_q   <= 3'd0;
      byteDone_q <= 1'b0;
      sdaOe_q    <= 1'b0;
      inFrame_q  <= 1'b1;
    end else if (stopCond) begin
      state_q   <= LK_IDLE;
      sdaOe_q   <= 1'b0;
      inFrame_q <= 1'b0;
    end else begin
      unique case (state_q)
        LK_IDLE, LK_WAIT: begin
        end
        LK_ADDR, LK_RXBYTE: begin
          if (sclRise) begin
            shift_q    <= {shift_q[6:0], sdaS};
            bitCnt_q   <= bitCnt_q + 3'd1;
            byteDone_q <= bitCnt_q == 3'd7;
          end else if (byteEnd) begin
            byteDone_q <= 1'b0;
            state_q    <= LK_ACK;
            sdaOe_q    <= 1'b1;
            if (state_q == LK_ADDR) begin
              if (ownHit(shift_q, strap_q)) begin
                mode_q    <= shift_q[0] ? MD_READ : MD_WRITE;
                byteIdx_q <= shift_q[0] ? 2'd1 : 2'd0;
              end else if (isGc) begin
                mode_q    <= MD_GCALL;
                byteIdx_q <= 2'd0;
              end else if (isAra) begin
                mode_q <= MD_ARA;
              end else begin
                state_q <= LK_WAIT;
                sdaOe_q <= 1'b0;
              end
            end else if (mode_q == MD_WRITE) begin
              if (byteIdx_q == 2'd0) begin
                ptr_q <= shift_q[1:0];
              end
              // Data bytes alternate hi, lo with no limit
              byteIdx_q <= (byteIdx_q == 2'd2) ? 2'd1 : byteIdx_q + 2'd1;
            end else begin
              byteIdx_q <= 2'd1;
              if (shift_q == GC_RESET) begin
                ptr_q <= PTR_RST;
              end
            end
          end
        end
        LK_ACK: begin
          if (sclFall) begin
            bitCnt_q <= 3'd0;
            if (mode_q == MD_READ || mode_q == MD_ARA) begin
              state_q  <= LK_TXBYTE;
              txByte_q <= txSrc;
              sdaOe_q  <= ~txSrc[7];
            end else if (mode_q == MD_GCALL && byteIdx_q == 2'd1) begin
              state_q <= LK_WAIT;
              sdaOe_q <= 1'b0;
            end else begin
              state_q <= LK_RXBYTE;
              sdaOe_q <= 1'b0;
            end
          end
        end
        LK_TXBYTE: begin
          if (sclRise && !sdaOe_q && !sdaS) begin
            state_q <= LK_WAIT;
          end else if (sclFall) begin
            if (bitCnt_q == 3'd7) begin
              state_q <= LK_TXACK;
              sdaOe_q <= 1'b0;
            end else begin
              bitCnt_q <= bitCnt_q + 3'd1;
              txByte_q <= {txByte_q[6:0], 1'b0};
              sdaOe_q  <= ~txByte_q[6];
            end
          end
        end
        LK_TXACK: begin
          if (sclRise) begin
            if (sdaS || mode_q == MD_ARA) begin
              state_q <= LK_WAIT;
            end else begin
              state_q   <= LK_TXNEXT;
              byteIdx_q <= (byteIdx_q == 2'd1) ? 2'd2 : 2'd1;
            end
          end
        end
        LK_TXNEXT: begin
          if (sclFall) begin
            state_q  <= LK_TXBYTE;
            txByte_q <= txSrc;
            sdaOe_q  <= ~txSrc[7];
            bitCnt_q <= 3'd0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request handshake, link side

  // Fields stay put until the next toggle, so the core may read them
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      reqTgl_q  <= 1'b0;
      reqKind_q <= RQ_READ;
      reqPtr_q  <= PTR_RST;
      reqData_q <= 8'h00;
    end else if (issue) begin
      reqTgl_q  <= ~reqTgl_q;
      reqKind_q <= issueKind;
      reqPtr_q  <= ptr_q;
      reqData_q <= shift_q;
    end
  end

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      rdWord_q <= 16'h0000;
    end else if (ackEv) begin
      rdWord_q <= rspWord_q;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_q;
  assign hsMode = hsMode_q;

  ////////////////////////////////////////////////////////////////////////
  // Core side

  tsi2c_sync #(.W(4), .RST_VAL(4'hc)) uCoreSync (
    .clk  (mclk),
    .rstn (rstn),
    .din  ({sclIn, sdaIn, inFrame_q, reqTgl_q}),
    .dout ({sclM, sdaM, frameM, reqTglS})
  );

  assign reqEv = reqTglS ^ reqTglP_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reqTglP_q <= 1'b0;
      rdDone_q  <= 1'b0;
    end else begin
      reqTglP_q <= reqTglS;
      rdDone_q  <= reqEv & (reqKind_q == RQ_READ);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ackTgl_q  <= 1'b0;
      rspWord_q <= 16'h0000;
    end else if (rdDone_q) begin
      ackTgl_q  <= ~ackTgl_q;
      rspWord_q <= rdData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      alertClr_q <= 1'b0;
      gcRst_q    <= 1'b0;
    end else begin
      alertClr_q <= reqEv & (((reqKind_q == RQ_READ) & alarmLatchingSelect) |
                             (reqKind_q == RQ_ARAWIN));
      gcRst_q    <= reqEv & (reqKind_q == RQ_GCRST);
    end
  end

  // Stuck-low watchdog counts on the core clock
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      toCnt_q <= '0;
      toTgl_q <= 1'b0;
    end else if (frameM && (!sclM || !sdaM)) begin
      if (toCnt_q == TO_W'(TimeoutCyc - 1)) begin
        toCnt_q <= '0;
        toTgl_q <= ~toTgl_q;
      end else begin
        toCnt_q <= toCnt_q + 1'b1;
      end
    end else begin
      toCnt_q <= '0;
    end
  end

  tsi2c_regfile uRegs (
    .mclk         (mclk),
    .rstn         (rstn),
    .clearAll     (reqEv & (reqKind_q == RQ_GCRST)),
    .wrEn         (reqEv & ((reqKind_q == RQ_WRHI) |
                            (reqKind_q == RQ_WRLO))),
    .wrHi         (reqKind_q == RQ_WRHI),
    .ptr          (reqPtr_q),
    .wrData       (reqData_q),
    .rdData       (rdData),
    .tempWord     (tempWord),
    .cfgWord      (cfgWord),
    .tLowWord     (tLowWord),
    .tHighWord    (tHighWord),
    .oneShotStart (oneShotStart)
  );

  assign alarmLatchingSelect = cfgWord[CFG_TM_BIT];
  assign alertClear          = alertClr_q;
  assign gcReset             = gcRst_q;

endmodule

// ==== rtl/tsi2c_sync.sv ====
// Two-flop level synchroniser
`timescale 1ns/100ps
module tsi2c_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the two-wire slave port
`timescale 1ns/100ps
module tb;
  import tsi2c_pkg::*;
  localparam int TO = 2000;
  logic        mclk;
  logic        linkClk;
  logic        rstn;
  logic        scl;
  logic        mPull;
  logic        sda;
  logic        sdaOe;
  logic [2:0]  strap;
  logic [11:0] tempWord;
  logic        alertActive;
  logic        alertHigh;
  logic        alertClear;
  logic        gcReset;
  logic        alarmLatchingSelect;
  logic [15:0] cfgWord;
  logic [15:0] tLowWord;
  logic [15:0] tHighWord;
  logic        hsMode;
  logic        clrSeen;
  logic        gcSeen;
  logic        oneShot;
  logic        osSeen;
  logic        ak;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [15:0] w;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;

  // Pull-up wins unless someone pulls low
  assign sda = !(mPull || sdaOe);

  tsi2c_bus_master tsi2c_bus_master_inst (
    .scl(scl), .sdaPull(mPull), .sda(sda)
  );

  tsi2c_slave_port #(
    .TimeoutCyc(TO)
  ) tsi2c_slave_port_inst (
    .mclk(mclk), .rstn(rstn), .linkClk(linkClk),
    .sclIn(scl), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe),
    .addrStrap0(strap[0]), .addrStrap1(strap[1]), .addrStrap2(strap[2]),
    .tempWord(tempWord), .alertActive(alertActive), .alertHigh(alertHigh),
    .alertClear(alertClear), .gcReset(gcReset), .oneShotStart(oneShot),
    .alarmLatchingSelect(alarmLatchingSelect), .cfgWord(cfgWord),
    .tLowWord(tLowWord), .tHighWord(tHighWord), .hsMode(hsMode)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #15 linkClk = ~linkClk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (alertClear === 1'b1) clrSeen <= 1'b1;
    if (gcReset === 1'b1) gcSeen <= 1'b1;
    if (oneShot === 1'b1) osSeen <= 1'b1;
    if (cyc == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [6:0] ad();
    return {4'b1001, strap};
  endfunction

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic st();
    tsi2c_bus_master_inst.start();
  endtask
  task automatic sp();
    tsi2c_bus_master_inst.stop();
  endtask
  task automatic wb(input logic [7:0] d);
    tsi2c_bus_master_inst.wbyte(d, ak);
  endtask
  task automatic rb(input logic a, output logic [7:0] d);
    tsi2c_bus_master_inst.rbyte(a, d);
  endtask

  task automatic wr(input logic [7:0] p, input int n,
                    input logic [15:0] v, input logic rs);
    st();
    wb({ad(), 1'b0});
    chk(ak, 1'b1);
    wb(p);
    chk(ak, 1'b1);
    for (int i = 0; i < n; i++) begin
      wb(i[0] ? v[7:0] : v[15:8]);
      chk(ak, 1'b1);
    end
    if (!rs) sp();
  endtask

  task automatic rd();
    st();
    wb({ad(), 1'b1});
    chk(ak, 1'b1);
    rb(1'b1, b0);
    rb(1'b0, b1);
    sp();
    w = {b0, b1};
  endtask

  task automatic t_write_read();
    wr(8'h03, 2, 16'h1234, 1'b1);
    rd();
    chk(w, 16'h1230);
    chk(tHighWord, 16'h1230);
    wr(8'hfe, 1, 16'hab00, 1'b0);
    tick();
    chk(tLowWord, 16'hab00);
  endtask

  task automatic t_ptr_read();
    wr(8'h00, 0, 16'h0000, 1'b0);
    st();
    wb({ad(), 1'b1});
    chk(ak, 1'b1);
    rb(1'b1, b0);
    rb(1'b1, b1);
    chk({b0, b1}, 16'h3200);
    rb(1'b0, b0);
    sp();
    chk(b0, 8'h32);
    rd();
    chk(w, 16'h3200);
  endtask

  task automatic t_refuse();
    logic [7:0] bad [3] = '{8'h98, 8'h19, 8'h01};
    foreach (bad[i]) begin
      st();
      wb(bad[i]);
      chk(ak, 1'b0);
      sp();
    end
  endtask

  task automatic t_ara();
    wr(8'h01, 1, 16'h8200, 1'b0);
    chk(alarmLatchingSelect, 1'b1);
    chk(osSeen, 1'b1);
    chk(cfgWord, 16'h02ff);
    for (int h = 0; h < 2; h++) begin
      tick();
      alertActive = 1'b1;
      alertHigh = h[0];
      clrSeen = 1'b0;
      st();
      wb(8'h19);
      chk(ak, 1'b1);
      rb(1'b0, b0);
      sp();
      chk(b0, {ad(), h[0]});
      chk(clrSeen, 1'b1);
    end
    tick();
    clrSeen = 1'b0;
    rd();
    chk(clrSeen, 1'b1);
    tick();
    alertActive = 1'b0;
  endtask

  task automatic t_gc();
    tick();
    strap = 3'b010;
    st();
    wb(8'h00);
    chk(ak, 1'b1);
    wb(8'h04);
    chk(ak, 1'b1);
    sp();
    wr(8'h03, 2, 16'h5670, 1'b0);
    tick();
    gcSeen = 1'b0;
    st();
    wb(8'h00);
    wb(8'h06);
    sp();
    chk(gcSeen, 1'b1);
    chk(cfgWord, 16'h00ff);
    chk(tHighWord, 16'h0000);
  endtask

  task automatic t_hs();
    st();
    wb(8'h0b);
    chk(ak, 1'b0);
    chk(hsMode, 1'b1);
    st();
    wb({ad(), 1'b1});
    chk(ak, 1'b1);
    chk(hsMode, 1'b1);
    rb(1'b0, b0);
    sp();
    chk(hsMode, 1'b0);
  endtask

  // Stall SCL low while the ack is driven
  task automatic t_timeout();
    logic [7:0] a;
    a = {ad(), 1'b1};
    st();
    for (int i = 7; i >= 0; i--) begin
      tsi2c_bus_master_inst.bitx(a[i], ak);
    end
    repeat (10) @(posedge mclk);
    chk(sdaOe, 1'b1);
    repeat (TO + 100) @(posedge mclk);
    chk(sdaOe, 1'b0);
    sp();
    rd();
  endtask

  initial begin
    rstn = 1'b0;
    strap = 3'b101;
    tempWord = 12'h320;
    alertActive = 1'b0;
    alertHigh = 1'b0;
    clrSeen = 1'b0;
    gcSeen = 1'b0;
    osSeen = 1'b0;
    repeat (16) @(posedge mclk);
    #1;
    rstn = 1'b1;
    repeat (8) @(posedge mclk);
    t_write_read();
    t_ptr_read();
    t_refuse();
    t_ara();
    t_gc();
    t_hs();
    t_timeout();
    print_verdict();
  end
endmodule

// ==== verification/tsi2c_bus_master.sv ====
// Bit-level two-wire bus master facing the slave port
`timescale 1ns/100ps
module tsi2c_bus_master #(
  parameter int Q = 400
) (
  // Bus
  output logic      scl,
  output logic      sdaPull,
  input  wire logic sda
);
  // Clock idles high outside frames
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  // Quarter of 400 ns keeps SCL well above 1 kHz
  task automatic bitx(input logic b, output logic r);
    sdaPull = !b;
    #Q;
    scl = 1'b1;
    #Q;
    r = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  // Also serves as repeated start
  task automatic start();
    sdaPull = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sdaPull = 1'b1;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sdaPull = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sdaPull = 1'b0;
    #Q;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = !r;
  endtask

  task automatic rbyte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(!ackIt, r);
  endtask
endmodule

// ==== verification/tsi2c_slave_port_sva.sv ====
// Assertion checker for the two-wire slave port
`timescale 1ns/100ps
module tsi2c_slave_port_sva #(
  parameter int TimeoutCyc = 2000
) (
  // Clocks and reset
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        linkClk,
  // Bus
  input wire logic        sclIn,
  input wire logic        sdaIn,
  input wire logic        sdaOe,
  // Core side
  input wire logic        alertClear,
  input wire logic        gcReset,
  input wire logic        alarmLatchingSelect,
  input wire logic [15:0] cfgWord,
  input wire logic [15:0] tHighWord,
  input wire logic        hsMode
);
  import tsi2c_pkg::*;
  int oeCnt;

  // Length of the current stretch of pulling SDA low
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      oeCnt <= 0;
    end else begin
      oeCnt <= sdaOe ? oeCnt + 1 : 0;
    end
  end

  sequence s_hsEnter;
    $rose(hsMode);
  endsequence
  sequence s_stopSeen;
    sclIn && $rose(sdaIn);
  endsequence

  a_clr_one_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    alertClear |=> !alertClear) else $error("alert clear too long");
  a_gc_one_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    gcReset |=> !gcReset) else $error("reset pulse too long");
  a_gc_regs_reset: assert property (@(posedge mclk) disable iff (!rstn)
    gcReset |-> ##[0:6] (cfgWord == 16'h00ff && tHighWord == 16'h0000))
    else $error("registers not reset");
  a_byte_at_once: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(tHighWord) && tHighWord != 16'h0000 |->
      tHighWord[15:8] == $past(tHighWord[15:8]) ||
      tHighWord[7:0] == $past(tHighWord[7:0]))
    else $error("both limit bytes changed at once");
  a_tm_mirror: assert property (@(posedge mclk) disable iff (!rstn)
    alarmLatchingSelect == cfgWord[9] && cfgWord[7:0] == 8'hff &&
    !cfgWord[15]) else $error("config readback wrong");
  a_clr_needs_tm: assert property (@(posedge mclk) disable iff (!rstn)
    alertClear |-> $past(alarmLatchingSelect))
    else $error("alert clear in comparator mode");
  a_hs_no_ack: assert property (@(posedge linkClk) disable iff (!rstn)
    s_hsEnter |-> !sdaOe [*8]) else $error("master code acknowledged");
  a_hs_till_stop: assert property (@(posedge linkClk) disable iff (!rstn)
    s_stopSeen |-> ##[1:10] !hsMode) else $error("hs kept after stop");
  a_ack_stable: assert property (@(posedge linkClk) disable iff (!rstn)
    sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("SDA drive moved while SCL high");
  a_timeout_release: assert property (@(posedge mclk) disable iff (!rstn)
    oeCnt <= TimeoutCyc + 100) else $error("bus not released");
endmodule

bind tsi2c_slave_port tsi2c_slave_port_sva #(
  .TimeoutCyc(TimeoutCyc)
) tsi2c_slave_port_sva_inst (
  .mclk(mclk), .rstn(rstn), .linkClk(linkClk),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
  .alertClear(alertClear), .gcReset(gcReset),
  .alarmLatchingSelect(alarmLatchingSelect),
  .cfgWord(cfgWord), .tHighWord(tHighWord), .hsMode(hsMode)
);
